// file: common/rtcbr_pkg.sv
package rtcbr_pkg;
    // Register byte offsets (printed offsets, not all multiples of four,
    // so each is an index and the AXI byte address is four times it).
    localparam logic [18:0] RTCBR_IDX_FLAGS = 19'h7FFF0;
    localparam logic [18:0] RTCBR_IDX_AMONTH = 19'h7FFF6;
    localparam logic [18:0] RTCBR_IDX_WDOG = 19'h7FFF7;
    localparam logic [18:0] RTCBR_IDX_CTRL = 19'h7FFF8;
    localparam logic [18:0] RTCBR_IDX_SECS = 19'h7FFF9;
    localparam logic [18:0] RTCBR_IDX_WDAY = 19'h7FFFC;
    localparam logic [18:0] RTCBR_IDX_ALMREP = 19'h7FFF2;
    localparam logic [18:0] RTCBR_IDX_MISC = 19'h00001;
    localparam int RTCBR_ADDR_W = 21;

    // Field positions.
    localparam int RTCBR_BIT_HALT = 7;
    localparam int RTCBR_BIT_FTEST = 6;
    localparam int RTCBR_BIT_AFE = 7;
    localparam int RTCBR_BIT_ABE = 5;
    localparam int RTCBR_BIT_WDS = 7;
    localparam int RTCBR_BIT_BLOW = 4;
    localparam int RTCBR_BIT_AHIT = 6;
    localparam int RTCBR_BIT_WDF = 7;
    localparam int RTCBR_BIT_SIGN = 5;

    // Reset values.
    localparam logic [7:0] RTCBR_RST_BYTE = 8'h00;
    localparam logic [3:0] RTCBR_RST_REP = 4'h0;

    // Fixed-zero masks for writable bytes.
    localparam logic [7:0] RTCBR_MASK_AMONTH = 8'hBF;
    localparam logic [7:0] RTCBR_MASK_WDAY = 8'h47;

    // Alarm repeat encodings (top bit first).
    localparam logic [3:0] RTCBR_REP_SEC = 4'hF;
    localparam logic [3:0] RTCBR_REP_MIN = 4'hE;
    localparam logic [3:0] RTCBR_REP_HOUR = 4'hC;
    localparam logic [3:0] RTCBR_REP_DAY = 4'h8;

    // Timing.
    localparam longint RTCBR_CLK_HZ = 250000000;
    localparam longint RTCBR_FT_HZ = 512;
    localparam longint RTCBR_RLOW_MIN_MS = 20;
    localparam longint RTCBR_RLOW_MAX_MS = 100;
    localparam longint RTCBR_RHIZ_MIN_MS = 40;
    localparam longint RTCBR_RHIZ_MAX_MS = 200;
    localparam longint RTCBR_BATT_HOURS = 24;
    localparam longint RTCBR_FT_HALF_CYC = RTCBR_CLK_HZ / (2 * RTCBR_FT_HZ);
    // Midpoints inside the allowed windows.
    localparam longint RTCBR_RLOW_CYC =
        RTCBR_CLK_HZ / 1000 * (RTCBR_RLOW_MIN_MS + RTCBR_RLOW_MAX_MS) / 2;
    localparam longint RTCBR_RHIZ_CYC =
        RTCBR_CLK_HZ / 1000 * (RTCBR_RHIZ_MIN_MS + RTCBR_RHIZ_MAX_MS) / 2;
    localparam longint RTCBR_BATT_CYC =
        RTCBR_CLK_HZ * 3600 * RTCBR_BATT_HOURS;

    // Alarm rate decode.
    typedef enum logic [2:0] {
        RTCBR_RATE_NONE, RTCBR_RATE_SEC, RTCBR_RATE_MIN,
        RTCBR_RATE_HOUR, RTCBR_RATE_DAY
    } rtcbr_rate_t;

    // Reset output sequencer.
    typedef enum logic [1:0] {
        RTCBR_RS_IDLE, RTCBR_RS_WAIT_LOW, RTCBR_RS_HELD, RTCBR_RS_RELEASE
    } rtcbr_rst_t;

    // Open-drain pin drive.
    typedef struct packed {
        logic pull_n;
    } rtcbr_od_t;
endpackage

// file: logic/rtcbr_core.sv
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/10ps
module rtcbr_core
    import rtcbr_pkg::*;
#(
    parameter longint RLOW_CYC = RTCBR_RLOW_CYC,
    parameter longint RHIZ_CYC = RTCBR_RHIZ_CYC,
    parameter longint BATT_CYC = RTCBR_BATT_CYC,
    parameter longint FT_HALF = RTCBR_FT_HALF_CYC
) (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic [RTCBR_ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [RTCBR_ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic external_reset_in_n_i,
    input wire logic main_power_ok_i,
    input wire logic battery_below_min_i,
    input wire logic alarm_match_i,
    input wire logic watchdog_timeout_i,
    output logic interrupt_test_out_n_o,
    output logic reset_out_n_o,
    output logic [2:0] alarm_rate_o,
    output logic [5:0] cal_signed_o
);
    localparam longint MAX_CNT = BATT_CYC;

    // Check the timing parameters once at elaboration.
    if (RLOW_CYC < 1 || RHIZ_CYC < 1 || FT_HALF < 1 || BATT_CYC < 1 ||
        BATT_CYC >= 64'h0000_FFFF_FFFF_FFFF) begin : g_bad_timing
        $error("rtcbr_core: timing parameter out of range");
    end

    // Register state.
    logic [7:0] flags_r, amonth_r, wdog_r, ctrl_r, secs_r, wday_r;
    logic [3:0] rep_r;
    logic ft_pin_r, ft_tgl_r;
    logic [47:0] ft_cnt_r, batt_cnt_r, rst_cnt_r;
    logic pwr_s1_r, pwr_s2_r, pwr_d_r;
    logic bl_s1_r, bl_s2_r, rin_s1_r, rin_s2_r;
    logic irq_pull_r, rst_pull_r;
    rtcbr_rst_t rst_st_r;
    logic aw_hold_r, w_hold_r;
    logic [RTCBR_ADDR_W-1:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;

    // Byte address to register index.
    function automatic logic [18:0] idx_of(input logic [RTCBR_ADDR_W-1:0] a);
        idx_of = a[RTCBR_ADDR_W-1:2];
    endfunction

    // Write path: either channel may arrive first; both are held until used.
    wire aw_take = s_axi_awvalid_i && s_axi_awready_o;
    wire w_take = s_axi_wvalid_i && s_axi_wready_o;
    wire aw_have = aw_hold_r || aw_take;
    wire w_have = w_hold_r || w_take;
    wire [RTCBR_ADDR_W-1:0] wa = aw_hold_r ? aw_addr_r : s_axi_awaddr_i;
    wire [31:0] wd = w_hold_r ? w_data_r : s_axi_wdata_i;
    wire [3:0] ws = w_hold_r ? w_strb_r : s_axi_wstrb_i;
    wire wr_go = aw_have && w_have && !s_axi_bvalid_o;
    wire [18:0] widx = idx_of(wa);
    wire wr_en = wr_go && ws[0];
    wire wr_hit = widx == RTCBR_IDX_AMONTH || widx == RTCBR_IDX_WDOG ||
        widx == RTCBR_IDX_CTRL || widx == RTCBR_IDX_SECS ||
        widx == RTCBR_IDX_WDAY || widx == RTCBR_IDX_ALMREP ||
        widx == RTCBR_IDX_FLAGS || widx == RTCBR_IDX_MISC;

    // Read path decode.
    wire rd_go = s_axi_arvalid_i && s_axi_arready_o;
    wire [18:0] ridx = idx_of(s_axi_araddr_i);
    wire flags_rd = rd_go && ridx == RTCBR_IDX_FLAGS;
    logic [31:0] rd_mux;
    logic rd_hit;
    always_comb begin
        rd_hit = 1'b1;
        case (ridx)
            RTCBR_IDX_FLAGS: rd_mux = {24'h000000, flags_r};
            RTCBR_IDX_AMONTH: rd_mux = {24'h000000, amonth_r};
            RTCBR_IDX_WDOG: rd_mux = {24'h000000, wdog_r};
            RTCBR_IDX_CTRL: rd_mux = {24'h000000, ctrl_r};
            RTCBR_IDX_SECS: rd_mux = {24'h000000, secs_r};
            RTCBR_IDX_WDAY: rd_mux = {24'h000000, wday_r};
            RTCBR_IDX_ALMREP: rd_mux = {28'h0000000, rep_r};
            RTCBR_IDX_MISC: rd_mux = {29'h00000000, alarm_rate_o};
            default: begin
                rd_mux = 32'h00000000;
                rd_hit = 1'b0;
            end
        endcase
    end

    // Pin inputs pass two flip-flops.
    always_ff @(posedge ref_clk_i) begin
        pwr_s1_r <= main_power_ok_i;
        pwr_s2_r <= pwr_s1_r;
        bl_s1_r <= battery_below_min_i;
        bl_s2_r <= bl_s1_r;
        rin_s1_r <= external_reset_in_n_i;
        rin_s2_r <= rin_s1_r;
    end

    // Power-up edge and battery check schedule.
    wire pwr_rise = pwr_s2_r && !pwr_d_r;
    wire batt_due = pwr_rise || (pwr_s2_r && batt_cnt_r == 48'(BATT_CYC - 1));
    wire batt_chk = batt_due && pwr_s2_r;

    // Alarm rate decode from repeat bits, top bit first.
    rtcbr_rate_t rate;
    assign rate = rep_r == RTCBR_REP_SEC ? RTCBR_RATE_SEC :
        rep_r == RTCBR_REP_MIN ? RTCBR_RATE_MIN :
        rep_r == RTCBR_REP_HOUR ? RTCBR_RATE_HOUR :
        rep_r == RTCBR_REP_DAY ? RTCBR_RATE_DAY : RTCBR_RATE_NONE;

    // Test output gating; calibration bits take no part in it.
    wire wd_ok = wdog_r[RTCBR_BIT_WDS] || wdog_r == RTCBR_RST_BYTE;
    wire ft_on = !secs_r[RTCBR_BIT_HALT] && wday_r[RTCBR_BIT_FTEST] &&
        !amonth_r[RTCBR_BIT_AFE] && wd_ok;
    wire alarm_pull = amonth_r[RTCBR_BIT_AFE] && flags_r[RTCBR_BIT_AHIT];
    wire wd_pull = !wdog_r[RTCBR_BIT_WDS] && flags_r[RTCBR_BIT_WDF];

    // Bus handshake registers.
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            aw_addr_r <= '0;
            w_data_r <= 32'h00000000;
            w_strb_r <= 4'h0;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= 2'h0;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rresp_o <= 2'h0;
            s_axi_rdata_o <= 32'h00000000;
        end else begin
            aw_hold_r <= aw_have && !wr_go;
            w_hold_r <= w_have && !wr_go;
            if (aw_take) begin
                aw_addr_r <= s_axi_awaddr_i;
            end
            if (w_take) begin
                w_data_r <= s_axi_wdata_i;
                w_strb_r <= s_axi_wstrb_i;
            end
            if (wr_go) begin
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o <= wr_hit ? 2'h0 : 2'h2;
            end else if (s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
            end
            if (rd_go) begin
                s_axi_rvalid_o <= 1'b1;
                s_axi_rdata_o <= rd_mux;
                s_axi_rresp_o <= rd_hit ? 2'h0 : 2'h2;
            end else if (s_axi_rready_i) begin
                s_axi_rvalid_o <= 1'b0;
            end
        end
    end

    // Ready flags stand while the channel is free.
    assign s_axi_awready_o = !aw_hold_r && !s_axi_bvalid_o;
    assign s_axi_wready_o = !w_hold_r && !s_axi_bvalid_o;
    assign s_axi_arready_o = !s_axi_rvalid_o;

    // Register file; reset stands for application of power.
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            wdog_r <= RTCBR_RST_BYTE;
            amonth_r <= RTCBR_RST_BYTE;
            ctrl_r <= RTCBR_RST_BYTE;
            wday_r <= RTCBR_RST_BYTE;
            secs_r <= RTCBR_RST_BYTE;
            rep_r <= RTCBR_RST_REP;
            flags_r <= RTCBR_RST_BYTE;
            pwr_d_r <= 1'b0;
            batt_cnt_r <= 48'h000000000000;
        end else begin
            pwr_d_r <= pwr_s2_r;
            batt_cnt_r <= (batt_due || !pwr_s2_r) ? 48'h000000000000 :
                batt_cnt_r + 48'h000000000001;
            if (wr_en && widx == RTCBR_IDX_WDOG) begin
                wdog_r <= wd[7:0];
            end
            if (wr_en && widx == RTCBR_IDX_AMONTH) begin
                amonth_r <= wd[7:0] & RTCBR_MASK_AMONTH;
            end
            if (wr_en && widx == RTCBR_IDX_CTRL) begin
                ctrl_r <= wd[7:0];
            end
            if (wr_en && widx == RTCBR_IDX_SECS) begin
                secs_r <= wd[7:0];
            end
            if (wr_en && widx == RTCBR_IDX_WDAY) begin
                wday_r <= wd[7:0] & RTCBR_MASK_WDAY;
            end
            if (wr_en && widx == RTCBR_IDX_ALMREP) begin
                rep_r <= wd[3:0];
            end
            // Event flags: set wins over the read-clear.
            flags_r[3:0] <= 4'h0;
            flags_r[RTCBR_BIT_SIGN] <= 1'b0;
            flags_r[RTCBR_BIT_WDF] <= watchdog_timeout_i ||
                (flags_r[RTCBR_BIT_WDF] && !flags_rd);
            flags_r[RTCBR_BIT_AHIT] <= alarm_match_i ||
                (flags_r[RTCBR_BIT_AHIT] && !flags_rd);
            if (batt_chk) begin
                flags_r[RTCBR_BIT_BLOW] <= bl_s2_r;
            end
        end
    end

    // 512 Hz divider runs from the undivided clock, ahead of calibration.
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            ft_cnt_r <= 48'h000000000000;
            ft_tgl_r <= 1'b0;
            irq_pull_r <= 1'b0;
        end else begin
            if (!ft_on || ft_cnt_r == 48'(FT_HALF - 1)) begin
                ft_cnt_r <= 48'h000000000000;
            end else begin
                ft_cnt_r <= ft_cnt_r + 48'h000000000001;
            end
            if (!ft_on) begin
                ft_tgl_r <= 1'b0;
            end else if (ft_cnt_r == 48'(FT_HALF - 1)) begin
                ft_tgl_r <= !ft_tgl_r;
            end
            irq_pull_r <= (alarm_pull || wd_pull) ? 1'b1 :
                (ft_on && ft_tgl_r);
        end
    end

    // Reset output sequencer.
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            rst_st_r <= RTCBR_RS_IDLE;
            rst_cnt_r <= 48'h000000000000;
            rst_pull_r <= 1'b0;
        end else begin
            case (rst_st_r)
                RTCBR_RS_IDLE: begin
                    rst_cnt_r <= 48'h000000000000;
                    if (!rin_s2_r) begin
                        rst_st_r <= RTCBR_RS_WAIT_LOW;
                    end
                end
                RTCBR_RS_WAIT_LOW: begin
                    rst_cnt_r <= rst_cnt_r + 48'h000000000001;
                    if (rin_s2_r) begin
                        rst_st_r <= RTCBR_RS_IDLE;
                    end else if (rst_cnt_r == 48'(RLOW_CYC - 1)) begin
                        rst_st_r <= RTCBR_RS_HELD;
                        rst_pull_r <= 1'b1;
                    end
                end
                RTCBR_RS_HELD: begin
                    rst_cnt_r <= 48'h000000000000;
                    if (rin_s2_r) begin
                        rst_st_r <= RTCBR_RS_RELEASE;
                    end
                end
                RTCBR_RS_RELEASE: begin
                    rst_cnt_r <= rst_cnt_r + 48'h000000000001;
                    if (!rin_s2_r) begin
                        rst_st_r <= RTCBR_RS_HELD;
                    end else if (rst_cnt_r == 48'(RHIZ_CYC - 1)) begin
                        rst_st_r <= RTCBR_RS_IDLE;
                        rst_pull_r <= 1'b0;
                    end
                end
                default: begin
                    rst_st_r <= RTCBR_RS_IDLE;
                end
            endcase
        end
    end

    // Registered outputs.
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            interrupt_test_out_n_o <= 1'b1;
            reset_out_n_o <= 1'b1;
            alarm_rate_o <= 3'h0;
            cal_signed_o <= 6'h00;
        end else begin
            interrupt_test_out_n_o <= !irq_pull_r;
            reset_out_n_o <= !rst_pull_r;
            alarm_rate_o <= rate;
            cal_signed_o <= ctrl_r[5:0];
        end
    end
endmodule

// file: verification/rtcbr_chk.sv
`timescale 1ns/10ps
module rtcbr_chk #(
    parameter longint RLOW_CYC = 20,
    parameter longint RHIZ_CYC = 30
) (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_wready_o,
    input wire logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic external_reset_in_n_i,
    input wire logic reset_out_n_o,
    input wire logic [2:0] alarm_rate_o
);
    logic [31:0] low_cnt_r;
    logic [31:0] high_cnt_r;
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (srst_i);
    // Saturating counts of how long the reset input has held each level.
    always_ff @(posedge ref_clk_i) begin
        if (srst_i || external_reset_in_n_i) low_cnt_r <= '0;
        else if (low_cnt_r != '1) low_cnt_r <= low_cnt_r + 1;
        if (srst_i || !external_reset_in_n_i) high_cnt_r <= '0;
        else if (high_cnt_r != '1) high_cnt_r <= high_cnt_r + 1;
    end
    chk_rst_fall_early: assert property (
        $fell(reset_out_n_o) |-> low_cnt_r >= 32'(RLOW_CYC))
        else $error("Reset output fell too early.");
    chk_rst_fall_late: assert property (
        low_cnt_r == 32'(RLOW_CYC + 8) |-> !reset_out_n_o)
        else $error("Reset output did not fall in time.");
    chk_rst_rise_early: assert property (
        $rose(reset_out_n_o) |-> high_cnt_r >= 32'(RHIZ_CYC))
        else $error("Reset output released too early.");
    chk_rst_rise_late: assert property (
        high_cnt_r == 32'(RHIZ_CYC + 8) |-> reset_out_n_o)
        else $error("Reset output not released in time.");
    chk_bresp_hold: assert property (
        s_axi_bvalid_o && !s_axi_bready_i |=>
        s_axi_bvalid_o && $stable(s_axi_bresp_o))
        else $error("Write response dropped before it was taken.");
    chk_rdata_hold: assert property (
        s_axi_rvalid_o && !s_axi_rready_i |=>
        s_axi_rvalid_o && $stable(s_axi_rdata_o))
        else $error("Read data dropped before it was taken.");
    chk_read_answer: assert property (
        s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
        else $error("Read answer late.");
    chk_ready_block: assert property (
        s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
        else $error("Write accepted while a response is pending.");
    chk_rate_code: assert property (
        alarm_rate_o <= 3'h4)
        else $error("Alarm rate code out of range.");
endmodule
bind rtcbr_core rtcbr_chk #(.RLOW_CYC(RLOW_CYC), .RHIZ_CYC(RHIZ_CYC))
    rtcbr_chk_inst (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i),
    .s_axi_awready_o(s_axi_awready_o), .s_axi_wready_o(s_axi_wready_o),
    .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
    .s_axi_bready_i(s_axi_bready_i), .s_axi_arvalid_i(s_axi_arvalid_i),
    .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
    .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
    .external_reset_in_n_i(external_reset_in_n_i),
    .reset_out_n_o(reset_out_n_o), .alarm_rate_o(alarm_rate_o)
);

// file: verification/rtcbr_host.sv
`timescale 1ns/10ps
module rtcbr_host
    import rtcbr_pkg::*;
(
    input wire logic ref_clk_i,
    output logic [RTCBR_ADDR_W-1:0] awaddr_o,
    output logic awvalid_o,
    input wire logic awready_i,
    output logic [31:0] wdata_o,
    output logic [3:0] wstrb_o,
    output logic wvalid_o,
    input wire logic wready_i,
    input wire logic [1:0] bresp_i,
    input wire logic bvalid_i,
    output logic bready_o,
    output logic [RTCBR_ADDR_W-1:0] araddr_o,
    output logic arvalid_o,
    input wire logic arready_i,
    input wire logic [31:0] rdata_i,
    input wire logic [1:0] rresp_i,
    input wire logic rvalid_i,
    output logic rready_o
);
    // The bus is idle at time zero.
    initial begin
        {awvalid_o, wvalid_o, bready_o, arvalid_o, rready_o} = '0;
        {awaddr_o, araddr_o, wdata_o, wstrb_o} = '0;
    end
    // One write; a taken channel shows its address or data inverted, while wstrb keeps its value.
    task automatic wr(input logic [18:0] idx, input logic [7:0] d,
                      input int dly, output logic [1:0] resp);
        int n;
        n = 0;
        @(posedge ref_clk_i);
        awaddr_o <= {idx, 2'b00};
        wdata_o <= {24'h000000, d};
        wstrb_o <= 4'h1;
        {awvalid_o, wvalid_o} <= 2'b11;
        bready_o <= (dly == 0);
        forever begin
            @(posedge ref_clk_i);
            n++;
            if (awvalid_o && awready_i) begin
                awvalid_o <= 1'b0;
                awaddr_o <= ~awaddr_o;
            end
            if (wvalid_o && wready_i) begin
                wvalid_o <= 1'b0;
                wdata_o <= ~wdata_o;
            end
            if (bready_o && bvalid_i) begin
                resp = bresp_i;
                bready_o <= 1'b0;
                break;
            end
            if (n >= dly) bready_o <= 1'b1;
        end
    endtask
    // One read; rready may be raised late to stall the answer.
    task automatic rd(input logic [18:0] idx, input int dly,
                      output logic [31:0] d, output logic [1:0] resp);
        int n;
        n = 0;
        @(posedge ref_clk_i);
        araddr_o <= {idx, 2'b00};
        arvalid_o <= 1'b1;
        rready_o <= (dly == 0);
        forever begin
            @(posedge ref_clk_i);
            n++;
            if (arvalid_o && arready_i) begin
                arvalid_o <= 1'b0;
                araddr_o <= ~araddr_o;
            end
            if (rready_o && rvalid_i) begin
                d = rdata_i;
                resp = rresp_i;
                rready_o <= 1'b0;
                break;
            end
            if (n >= dly) rready_o <= 1'b1;
        end
    endtask
endmodule

// file: verification/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import rtcbr_pkg::*;
    localparam longint RLOW = 20;
    localparam longint RHIZ = 30;
    localparam longint BATT = 200;
    logic ref_clk_i, srst_i, ext_n, pwr_ok, batt_lo, alm, wdt, int_n, rst_n;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [RTCBR_ADDR_W-1:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd_v, seed;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rsp;
    logic [2:0] rate;
    logic [5:0] cal;
    logic [7:0] v;
    int n_fail, checked, t;
    logic [18:0] def_idx [4] = '{RTCBR_IDX_AMONTH, RTCBR_IDX_WDOG,
                                 RTCBR_IDX_CTRL, RTCBR_IDX_WDAY};
    logic [3:0] reps [5] = '{4'hF, 4'hE, 4'hC, 4'h8, 4'h0};
    rtcbr_core #(.RLOW_CYC(RLOW), .RHIZ_CYC(RHIZ), .BATT_CYC(BATT),
                 .FT_HALF(4)) rtcbr_core_inst (
        .ref_clk_i(ref_clk_i), .srst_i(srst_i), .s_axi_awaddr_i(awaddr),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
        .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .external_reset_in_n_i(ext_n),
        .main_power_ok_i(pwr_ok), .battery_below_min_i(batt_lo),
        .alarm_match_i(alm), .watchdog_timeout_i(wdt),
        .interrupt_test_out_n_o(int_n), .reset_out_n_o(rst_n),
        .alarm_rate_o(rate), .cal_signed_o(cal));
    rtcbr_host rtcbr_host_inst (
        .ref_clk_i(ref_clk_i), .awaddr_o(awaddr), .awvalid_o(awvalid),
        .awready_i(awready), .wdata_o(wdata), .wstrb_o(wstrb),
        .wvalid_o(wvalid), .wready_i(wready), .bresp_i(bresp),
        .bvalid_i(bvalid), .bready_o(bready), .araddr_o(araddr),
        .arvalid_o(arvalid), .arready_i(arready), .rdata_i(rdata),
        .rresp_i(rresp), .rvalid_i(rvalid), .rready_o(rready));
    // Repeatable pseudo-random source.
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    // Expected alarm rate code from the repeat bits, top bit first.
    function automatic logic [2:0] exp_rate(input logic [3:0] r);
        case (r)
            4'hF: return 3'h1;
            4'hE: return 3'h2;
            4'hC: return 3'h3;
            4'h8: return 3'h4;
            default: return 3'h0;
        endcase
    endfunction
    task automatic check(input logic ok, input string msg);
        checked++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask
    task automatic print_verdict;
        $display("checked %0d, failed %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Bus accesses with a random response stall.
    task automatic wr(input logic [18:0] i, input logic [7:0] d);
        seed = xs(seed);
        rtcbr_host_inst.wr(i, d, int'(seed[1:0]), rsp);
    endtask
    task automatic rd(input logic [18:0] i);
        seed = xs(seed);
        rtcbr_host_inst.rd(i, int'(seed[1:0]), rd_v, rsp);
    endtask
    // Counts pin changes over 40 cycles after a short settling wait.
    task automatic ft_chk(input int lo, input int hi, input string msg);
        logic last;
        int n;
        n = 0;
        repeat (4) @(negedge ref_clk_i);
        last = int_n;
        repeat (40) begin
            @(negedge ref_clk_i);
            if (int_n !== last) n++;
            last = int_n;
        end
        check(n >= lo && n <= hi, msg);
    endtask
    task automatic defaults;
        foreach (def_idx[i]) begin
            rd(def_idx[i]);
            check(rd_v[7:0] === RTCBR_RST_BYTE, "power-on value");
        end
    endtask
    // Free-running clock.
    initial begin
        ref_clk_i = 1'b0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end
    // Hang guard.
    initial begin
        #200000;
        n_fail++;
        $display("CHECK FAILED at %0t: timeout", $time);
        print_verdict;
    end
    // Main sequence.
    initial begin
        {srst_i, ext_n, pwr_ok, batt_lo, alm, wdt} = 6'b111000;
        {n_fail, checked} = '0;
        seed = 32'h0000C26B;
        repeat (3) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        defaults;
        rd(19'h00100);
        check(rsp === 2'h2 && rd_v === 32'h0, "unmapped read");
        wr(RTCBR_IDX_FLAGS, 8'hFF);
        check(rsp === 2'h0, "flags write okay");
        rd(RTCBR_IDX_FLAGS);
        check(rd_v[7:4] === 4'h0, "flags are read-only");
        foreach (reps[i]) begin
            wr(RTCBR_IDX_ALMREP, {4'h0, reps[i]});
            repeat (2) @(negedge ref_clk_i);
            check(rate === exp_rate(reps[i]), "alarm rate");
        end
        for (int i = 0; i < 6; i++) begin
            seed = xs(seed);
            v = (i == 0) ? 8'h0A : (seed[7:0] & 8'h3F);
            wr(RTCBR_IDX_CTRL, v);
            repeat (2) @(negedge ref_clk_i);
            check(cal === v[5:0], "calibration field");
            rd(RTCBR_IDX_CTRL);
            check(rd_v[7:0] === v, "control readback");
        end
        wr(RTCBR_IDX_WDAY, 8'h40);
        ft_chk(9, 11, "test output toggles");
        wr(RTCBR_IDX_CTRL, 8'h3F);
        ft_chk(9, 11, "calibration leaves test rate");
        wr(RTCBR_IDX_WDOG, 8'h05);
        ft_chk(0, 0, "watchdog on pin blocks test");
        wr(RTCBR_IDX_WDOG, 8'h85);
        ft_chk(9, 11, "watchdog steered away");
        wr(RTCBR_IDX_SECS, 8'h80);
        ft_chk(0, 0, "halted oscillator blocks test");
        wr(RTCBR_IDX_SECS, 8'h00);
        wr(RTCBR_IDX_AMONTH, 8'h80);
        ft_chk(0, 0, "alarm enable blocks test");
        @(posedge ref_clk_i) alm <= 1'b1;
        @(posedge ref_clk_i) alm <= 1'b0;
        repeat (3) @(negedge ref_clk_i);
        check(int_n === 1'b0, "alarm owns pin");
        rd(RTCBR_IDX_FLAGS);
        check(rd_v[RTCBR_BIT_AHIT] === 1'b1, "alarm flag set");
        rd(RTCBR_IDX_FLAGS);
        check(rd_v[RTCBR_BIT_AHIT] === 1'b0, "alarm flag cleared by read");
        wr(RTCBR_IDX_AMONTH, 8'h00);
        wr(RTCBR_IDX_WDOG, 8'h05);
        @(posedge ref_clk_i) wdt <= 1'b1;
        @(posedge ref_clk_i) wdt <= 1'b0;
        repeat (3) @(negedge ref_clk_i);
        check(int_n === 1'b0, "watchdog owns pin");
        rd(RTCBR_IDX_FLAGS);
        check(rd_v[RTCBR_BIT_WDF] === 1'b1, "watchdog flag set");
        @(posedge ref_clk_i) {pwr_ok, batt_lo} <= 2'b01;
        repeat (3 * BATT) @(posedge ref_clk_i);
        rd(RTCBR_IDX_FLAGS);
        check(rd_v[RTCBR_BIT_BLOW] === 1'b0, "no check on back-up");
        batt_lo <= 1'b0;
        @(posedge ref_clk_i) pwr_ok <= 1'b1;
        @(posedge ref_clk_i) batt_lo <= 1'b1;
        repeat (BATT + 20) @(posedge ref_clk_i);
        rd(RTCBR_IDX_FLAGS);
        check(rd_v[RTCBR_BIT_BLOW] === 1'b1, "periodic check");
        wr(RTCBR_IDX_AMONTH, 8'hA0);
        @(posedge ref_clk_i) srst_i <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        defaults;
        rd(RTCBR_IDX_FLAGS);
        check(rd_v[RTCBR_BIT_BLOW] === 1'b1, "power-up check");
        @(posedge ref_clk_i) ext_n <= 1'b0;
        repeat (10) @(posedge ref_clk_i);
        ext_n <= 1'b1;
        t = 0;
        repeat (40) begin
            @(negedge ref_clk_i);
            if (rst_n !== 1'b1) t++;
        end
        check(t == 0, "short pulse ignored");
        @(posedge ref_clk_i) ext_n <= 1'b0;
        repeat (RLOW - 2) @(negedge ref_clk_i);
        check(rst_n === 1'b1, "reset output held off");
        repeat (12) @(negedge ref_clk_i);
        check(rst_n === 1'b0, "reset output low");
        @(posedge ref_clk_i) ext_n <= 1'b1;
        repeat (RHIZ - 2) @(negedge ref_clk_i);
        check(rst_n === 1'b0, "release held off");
        repeat (12) @(negedge ref_clk_i);
        check(rst_n === 1'b1, "reset output released");
        print_verdict;
    end
endmodule
